/* File: hw/artx_pkg.sv */
// Package: opcodes, widths and reset values for the register-transfer unit
package artx_pkg;
	// ---------------------------------------------------------------
	// Instruction codes (10-bit program words)
	// ---------------------------------------------------------------
	localparam logic [9:0] OP_LOAD_ACC_FROM_PTR  = 10'h053;
	localparam logic [9:0] OP_LOAD_THREE_FROM_ACC = 10'h029;
	localparam logic [9:0] OP_LOAD_BYTE_FROM_AB  = 10'h01a;
	localparam logic [9:0] OP_LOAD_CFG_FIRST     = 10'h228;
	localparam logic [9:0] OP_LOAD_CFG_SECOND    = 10'h229;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] ACC_RST   = 4'h0;
	localparam logic [2:0] THREE_RST = 3'h0;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [3:0] CFG_RST   = 4'h0;

	// Instruction kinds, one-hot
	typedef enum logic [5:0] {
		ARTX_NONE   = 6'h01,
		ARTX_PTR    = 6'h02,
		ARTX_THREE  = 6'h04,
		ARTX_BYTE   = 6'h08,
		ARTX_CFG0   = 6'h10,
		ARTX_CFG1   = 6'h20
	} artx_op_type;
endpackage

/* File: hw/artx_decode.sv */
// Opcode decoder for the register-transfer unit
`timescale 1ns/1ps
module artx_decode
	import artx_pkg::*;
(
	input  wire logic [9:0] opcode_i,
	output artx_op_type     op_o
);
	always_comb begin
		unique case (opcode_i)
			OP_LOAD_ACC_FROM_PTR:   op_o = ARTX_PTR;
			OP_LOAD_THREE_FROM_ACC: op_o = ARTX_THREE;
			OP_LOAD_BYTE_FROM_AB:   op_o = ARTX_BYTE;
			OP_LOAD_CFG_FIRST:      op_o = ARTX_CFG0;
			OP_LOAD_CFG_SECOND:     op_o = ARTX_CFG1;
			default:                op_o = ARTX_NONE;
		endcase
	end
endmodule

/* File: hw/artx_core.sv */
// Execution of accumulator register-transfer instructions
`timescale 1ns/1ps
module artx_core
	import artx_pkg::*;
(
	input  wire logic       CLK_I,
	input  wire logic       SRST_I,
	input  wire logic       EXEC_I,
	input  wire logic [9:0] OPCODE_I,
	input  wire logic [3:0] ACC_I,
	input  wire logic [1:0] POINTER_I,
	input  wire logic [3:0] AUX_I,
	input  wire logic       CARRY_I,
	output logic            ACC_WE_O,
	output logic      [3:0] ACC_O,
	output logic      [2:0] THREE_REG_O,
	output logic      [7:0] BYTE_REG_O,
	output logic      [3:0] PORT_OUTPUT_CFG_FIRST_O,
	output logic      [3:0] PORT_OUTPUT_CFG_SECOND_O,
	output logic            CARRY_O,
	output logic            SKIP_O,
	output logic            DONE_O
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] acc;
		logic       acc_we;
		logic [2:0] three;
		logic [7:0] byte_reg;
		logic [3:0] cfg0;
		logic [3:0] cfg1;
		logic       done;
	} artx_state_type;

	artx_state_type state_r;
	artx_state_type state_nxt;
	artx_op_type    op;
	logic           issue_ptr;
	logic           issue_three;
	logic           issue_byte;
	logic           issue_cfg0;
	logic           issue_cfg1;
	logic           issue_any;

	localparam artx_state_type STATE_RST = '{
		acc:      ACC_RST,
		acc_we:   1'h0,
		three:    THREE_RST,
		byte_reg: BYTE_RST,
		cfg0:     CFG_RST,
		cfg1:     CFG_RST,
		done:     1'h0
	};

	// ---------------------------------------------------------------
	// Transfer arithmetic
	// ---------------------------------------------------------------
	// Upper accumulator bits are forced, never carried over
	function automatic logic [3:0] acc_from_ptr(
		input logic [1:0] ptr
	);
		return {2'h0, ptr};
	endfunction

	// Accumulator msb dropped: the target holds only three bits
	function automatic logic [2:0] three_from_acc(
		input logic [3:0] acc
	);
		return acc[2:0];
	endfunction

	function automatic logic [7:0] pack_byte(
		input logic [3:0] aux,
		input logic [3:0] acc
	);
		return {aux, acc};
	endfunction

	// ---------------------------------------------------------------
	// Decoder
	// ---------------------------------------------------------------
	artx_decode u_dec (
		.opcode_i (OPCODE_I),
		.op_o     (op)
	);

	// ---------------------------------------------------------------
	// Issue strobes
	// ---------------------------------------------------------------
	// Unknown words decode to the idle kind and never issue
	assign issue_ptr   = EXEC_I && (op == ARTX_PTR);
	assign issue_three = EXEC_I && (op == ARTX_THREE);
	assign issue_byte  = EXEC_I && (op == ARTX_BYTE);
	assign issue_cfg0  = EXEC_I && (op == ARTX_CFG0);
	assign issue_cfg1  = EXEC_I && (op == ARTX_CFG1);
	assign issue_any   = issue_ptr | issue_three | issue_byte
		| issue_cfg0 | issue_cfg1;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt        = state_r;
		state_nxt.acc_we = 1'h0;
		state_nxt.done   = issue_any;
		if (issue_ptr) begin
			state_nxt.acc    = acc_from_ptr(POINTER_I);
			state_nxt.acc_we = 1'h1;
		end
		if (issue_three) begin
			state_nxt.three = three_from_acc(ACC_I);
		end
		if (issue_byte) begin
			state_nxt.byte_reg = pack_byte(AUX_I, ACC_I);
		end
		if (issue_cfg0) begin
			state_nxt.cfg0 = ACC_I;
		end
		if (issue_cfg1) begin
			state_nxt.cfg1 = ACC_I;
		end
	end

	// ---------------------------------------------------------------
	// Register
	// ---------------------------------------------------------------
	// Synchronous reset only: the unit runs on the instruction clock
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			state_r <= STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign ACC_WE_O                 = state_r.acc_we;
	assign ACC_O                    = state_r.acc;
	assign THREE_REG_O              = state_r.three;
	assign BYTE_REG_O               = state_r.byte_reg;
	assign PORT_OUTPUT_CFG_FIRST_O  = state_r.cfg0;
	assign PORT_OUTPUT_CFG_SECOND_O = state_r.cfg1;
	// Carry passes straight through; no transfer here touches it
	assign CARRY_O                  = CARRY_I;
	assign SKIP_O                   = 1'b0;
	assign DONE_O                   = state_r.done;
endmodule

/* File: testbench/artx_props.sv */
// Checker for the register-transfer unit
`timescale 1ns/1ps
module artx_props
	import artx_pkg::*;
(
	input wire logic       CLK_I,
	input wire logic       SRST_I,
	input wire logic       EXEC_I,
	input wire logic [9:0] OPCODE_I,
	input wire logic [3:0] ACC_I,
	input wire logic [1:0] POINTER_I,
	input wire logic [3:0] AUX_I,
	input wire logic       CARRY_I,
	input wire logic       ACC_WE_O,
	input wire logic [3:0] ACC_O,
	input wire logic [2:0] THREE_REG_O,
	input wire logic [7:0] BYTE_REG_O,
	input wire logic [3:0] PORT_OUTPUT_CFG_FIRST_O,
	input wire logic [3:0] PORT_OUTPUT_CFG_SECOND_O,
	input wire logic       CARRY_O,
	input wire logic       SKIP_O,
	input wire logic       DONE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	sequence s_go(logic [9:0] op);
		EXEC_I && OPCODE_I == op;
	endsequence
	a_ptr_load: assert property (s_go(OP_LOAD_ACC_FROM_PTR) |=>
		ACC_WE_O && ACC_O == {2'h0, $past(POINTER_I)}) else $error("ptr");
	a_three_load: assert property (s_go(OP_LOAD_THREE_FROM_ACC) |=>
		THREE_REG_O == $past(ACC_I[2:0])) else $error("three");
	a_byte_load: assert property (s_go(OP_LOAD_BYTE_FROM_AB) |=>
		BYTE_REG_O == {$past(AUX_I), $past(ACC_I)}) else $error("byte");
	a_cfg_first: assert property (s_go(OP_LOAD_CFG_FIRST) |=>
		PORT_OUTPUT_CFG_FIRST_O == $past(ACC_I)) else $error("cfg0");
	a_cfg_second: assert property (s_go(OP_LOAD_CFG_SECOND) |=>
		PORT_OUTPUT_CFG_SECOND_O == $past(ACC_I)) else $error("cfg1");
	a_carry_skip: assert property (CARRY_O == CARRY_I && !SKIP_O)
		else $error("carry");
	a_idle_quiet: assert property (!EXEC_I |=> !DONE_O)
		else $error("done");
endmodule
bind artx_core artx_props artx_props_inst (
	.CLK_I                    (CLK_I),
	.SRST_I                   (SRST_I),
	.EXEC_I                   (EXEC_I),
	.OPCODE_I                 (OPCODE_I),
	.ACC_I                    (ACC_I),
	.POINTER_I                (POINTER_I),
	.AUX_I                    (AUX_I),
	.CARRY_I                  (CARRY_I),
	.ACC_WE_O                 (ACC_WE_O),
	.ACC_O                    (ACC_O),
	.THREE_REG_O              (THREE_REG_O),
	.BYTE_REG_O               (BYTE_REG_O),
	.PORT_OUTPUT_CFG_FIRST_O  (PORT_OUTPUT_CFG_FIRST_O),
	.PORT_OUTPUT_CFG_SECOND_O (PORT_OUTPUT_CFG_SECOND_O),
	.CARRY_O                  (CARRY_O),
	.SKIP_O                   (SKIP_O),
	.DONE_O                   (DONE_O)
);

/* File: testbench/artx_core_bench.sv */
// Random self-checking bench for the register-transfer unit
`timescale 1ns/1ps
module artx_core_bench;
	import artx_pkg::*;
	logic CLK_I = 0, SRST_I = 1, EXEC_I = 0, CARRY_I = 0;
	logic [9:0] OPCODE_I = 0;
	logic [3:0] ACC_I = 0, AUX_I = 0;
	logic [1:0] POINTER_I = 0;
	logic ACC_WE_O, CARRY_O, SKIP_O, DONE_O;
	logic [3:0] ACC_O, PORT_OUTPUT_CFG_FIRST_O, PORT_OUTPUT_CFG_SECOND_O;
	logic [2:0] THREE_REG_O;
	logic [7:0] BYTE_REG_O;
	logic [9:0] op;
	logic [31:0] r;
	logic [7:0] x [7], p [7];
	// Corners: high acc bits, msb drop, aux/acc order, idle, carry
	logic [31:0] corner [5] = '{32'h0000_07e8, 32'h0000_01e9,
		32'h0000_50aa, 32'h0000_01e3, 32'h0000_812c};
	int miscompares = 0, n_checks = 0, seed = 56153;
	always #25 CLK_I = ~CLK_I;
	artx_core artx_core_inst (
		.CLK_I                    (CLK_I),
		.SRST_I                   (SRST_I),
		.EXEC_I                   (EXEC_I),
		.OPCODE_I                 (OPCODE_I),
		.ACC_I                    (ACC_I),
		.POINTER_I                (POINTER_I),
		.AUX_I                    (AUX_I),
		.CARRY_I                  (CARRY_I),
		.ACC_WE_O                 (ACC_WE_O),
		.ACC_O                    (ACC_O),
		.THREE_REG_O              (THREE_REG_O),
		.BYTE_REG_O               (BYTE_REG_O),
		.PORT_OUTPUT_CFG_FIRST_O  (PORT_OUTPUT_CFG_FIRST_O),
		.PORT_OUTPUT_CFG_SECOND_O (PORT_OUTPUT_CFG_SECOND_O),
		.CARRY_O                  (CARRY_O),
		.SKIP_O                   (SKIP_O),
		.DONE_O                   (DONE_O)
	);
	function automatic logic known_op(input logic [9:0] w);
		return w == OP_LOAD_ACC_FROM_PTR || w == OP_LOAD_THREE_FROM_ACC
			|| w == OP_LOAD_BYTE_FROM_AB || w == OP_LOAD_CFG_FIRST
			|| w == OP_LOAD_CFG_SECOND;
	endfunction
	function automatic logic [3:0] exp_acc(input logic [1:0] ptr);
		return {2'h0, ptr};
	endfunction
	task chk(string nm, logic [7:0] e, logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		p[0] = 8'(THREE_RST);
		p[1] = BYTE_RST;
		p[2] = 8'(CFG_RST);
		p[3] = 8'(CFG_RST);
		p[4] = 8'h00;
		p[5] = 8'h00;
		p[6] = 8'(ACC_RST);
		repeat (20) @(posedge CLK_I);
		SRST_I <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			@(posedge CLK_I);
			x = p;
			r = (i < 5) ? corner[i] : $random(seed);
			// Unknown words mixed in to prove they are ignored
			case (r[2:0])
				0: op = OP_LOAD_ACC_FROM_PTR;
				1: op = OP_LOAD_THREE_FROM_ACC;
				2: op = OP_LOAD_BYTE_FROM_AB;
				3: op = OP_LOAD_CFG_FIRST;
				4: op = OP_LOAD_CFG_SECOND;
				default: op = r[31:22];
			endcase
			// Aux in r[14:11], pointer in r[10:9], acc in r[8:5]
			{EXEC_I, AUX_I, POINTER_I, ACC_I} <= {r[3] | r[4], r[14:5]};
			CARRY_I <= r[15];
			OPCODE_I <= op;
			p[4] = 8'(known_op(op) && (r[3] | r[4]));
			p[5] = 8'h00;
			if (r[3] | r[4]) begin
				case (op)
					OP_LOAD_ACC_FROM_PTR: begin
						p[5] = 8'h01;
						p[6] = 8'(exp_acc(r[10:9]));
					end
					OP_LOAD_THREE_FROM_ACC: p[0] = 8'(r[7:5]);
					OP_LOAD_BYTE_FROM_AB: p[1] = {r[14:11], r[8:5]};
					OP_LOAD_CFG_FIRST: p[2] = 8'(r[8:5]);
					OP_LOAD_CFG_SECOND: p[3] = 8'(r[8:5]);
					default: ;
				endcase
			end
			@(negedge CLK_I);
			chk("done", x[4], 8'(DONE_O));
			chk("we", x[5], 8'(ACC_WE_O));
			if (x[5] == 1) chk("acc", x[6], 8'(ACC_O));
			chk("three", x[0], 8'(THREE_REG_O));
			chk("byte", x[1], BYTE_REG_O);
			chk("cfg0", x[2], 8'(PORT_OUTPUT_CFG_FIRST_O));
			chk("cfg1", x[3], 8'(PORT_OUTPUT_CFG_SECOND_O));
			chk("cy", 8'(CARRY_I), 8'({SKIP_O, CARRY_O}));
		end
		finish_test();
	end
endmodule
